// [hdl/hbg_defines.svh]
// Offsets, field positions, reset values and timing counts of the gate logic.
`ifndef HBG_DEFINES_SVH
`define HBG_DEFINES_SVH

`define HBG_CLK_PERIOD_PS 5000
`define HBG_DEAD_NS       530
`define HBG_DEAD_CYC      ((`HBG_DEAD_NS * 1000 + `HBG_CLK_PERIOD_PS - 1) / `HBG_CLK_PERIOD_PS)
`define HBG_WIN_US        20
`define HBG_WIN_CYC       ((`HBG_WIN_US * 1000000) / `HBG_CLK_PERIOD_PS)

`define HBG_ADR_CTRL      8'h00
`define HBG_ADR_STATUS    8'h04
`define HBG_ADR_IRQ_STAT  8'h08
`define HBG_ADR_IRQ_EN    8'h0C
`define HBG_ADR_IRQ_CLR   8'h10

`define HBG_CTRL_DRIVE_EN 0
`define HBG_CTRL_RESET    1'h1

`define HBG_ST_HIGH_GATE  0
`define HBG_ST_LOW_GATE   1
`define HBG_ST_BOOT       2
`define HBG_ST_LOGIC_OK   3
`define HBG_ST_FLOAT_OK   4
`define HBG_ST_VB_HIGH    5
`define HBG_ST_WIN_OPEN   6

`define HBG_EV_LOGIC_UV   0
`define HBG_EV_FLOAT_UV   1
`define HBG_EV_STRETCH    2
`define HBG_EV_CROSS      3
`define HBG_EV_WIDTH      4

`endif

// [hdl/hbg_pkg.sv]
// Types shared by the half-bridge gate logic.
package hbg_pkg;

   typedef struct packed {
      logic logic_above_upper;
      logic logic_below_lower;
      logic float_above_upper;
      logic float_below_lower;
      logic vb_high;
   } hbg_sense_s;

   typedef enum logic [1:0] {
      HBG_WIN_IDLE,
      HBG_WIN_FIXED,
      HBG_WIN_RETRIG
   } hbg_win_e;

endpackage

// [hdl/hbg_gate_logic.sv]
// Half-bridge gate logic with deadtime, lockout, bootstrap control and Wishbone registers.
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hbg_defines.svh"

module hbg_gate_logic (
   // Clock and reset.
   input  wire logic              clock_in,
   input  wire logic              nrst_in,
   // Controller commands and comparator flags.
   input  wire logic              high_side_cmd_in,
   input  wire logic              low_side_cmd_n_in,
   input  wire hbg_pkg::hbg_sense_s sense_in,
   // Gate, bootstrap, fault and interrupt outputs.
   output logic                   high_gate_out,
   output logic                   low_gate_out,
   output logic                   boot_switch_out,
   output logic                   fault_n_out,
   output logic                   irq_out,
   // Wishbone slave.
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [7:0]        wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic [31:0]            wb_dat_out,
   output logic                   wb_ack_out
);

   localparam int DEAD_CYC = `HBG_DEAD_CYC;
   localparam int WIN_CYC  = `HBG_WIN_CYC;

   logic [6:0]              sync1_reg;
   logic [6:0]              sync2_reg;
   logic                    req_high;
   logic                    req_low;
   logic                    prev_req_high_reg;
   logic                    prev_req_low_reg;
   hbg_pkg::hbg_sense_s     sense_s;
   logic                    logic_ok_reg;
   logic                    float_ok_reg;
   logic                    high_gate_reg;
   logic                    low_gate_reg;
   logic [6:0]              dead_cnt_reg;
   logic                    dead_done;
   logic                    both_off;
   logic                    high_next;
   logic                    low_next;
   logic                    stretch;
   logic                    stretch_prev_reg;
   hbg_pkg::hbg_win_e       win_mode_reg;
   logic [11:0]             win_cnt_reg;
   logic                    boot_reg;
   logic                    ctrl_drive_en_reg;
   logic [`HBG_EV_WIDTH-1:0] irq_stat_reg;
   logic [`HBG_EV_WIDTH-1:0] irq_en_reg;
   logic [`HBG_EV_WIDTH-1:0] events;
   logic                    ack_reg;
   logic [31:0]             dat_reg;
   logic                    wb_req;
   logic                    wr_lane0;

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr[7:2] == off[7:2]);
   endfunction

   // The first stage is read only by the second one.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
      end else begin
         sync1_reg <= {high_side_cmd_in, low_side_cmd_n_in, sense_in};
         sync2_reg <= sync1_reg;
      end
   end

   assign req_high = sync2_reg[6];
   assign req_low  = ~sync2_reg[5];
   assign sense_s  = sync2_reg[4:0];

   // Lockout hysteresis comes from the pair of threshold flags.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         logic_ok_reg <= 1'b0;
         float_ok_reg <= 1'b0;
      end else begin
         if (sense_s.logic_below_lower) begin
            logic_ok_reg <= 1'b0;
         end else if (sense_s.logic_above_upper) begin
            logic_ok_reg <= 1'b1;
         end
         if (sense_s.float_below_lower) begin
            float_ok_reg <= 1'b0;
         end else if (sense_s.float_above_upper) begin
            float_ok_reg <= 1'b1;
         end
      end
   end

   assign both_off  = !high_gate_reg && !low_gate_reg;
   assign dead_done = (dead_cnt_reg >= 7'(DEAD_CYC));

   // Counter runs while both gates are off and saturates, so a long external gap
   // has already expired it when the next command arrives.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         dead_cnt_reg <= 7'(DEAD_CYC);
      end else if (!both_off) begin
         dead_cnt_reg <= 7'h00;
      end else if (!dead_done) begin
         dead_cnt_reg <= dead_cnt_reg + 7'h01;
      end
   end

   // Turn-off and turn-on both resolve in this single stage, which keeps
   // the four paths of equal latency.
   always_comb begin
      high_next = 1'b0;
      low_next  = 1'b0;
      stretch   = 1'b0;
      if (ctrl_drive_en_reg && logic_ok_reg && !(req_high && req_low)) begin
         if (req_high && float_ok_reg) begin
            high_next = high_gate_reg || (both_off && dead_done);
            stretch   = both_off && !dead_done;
         end
         if (req_low) begin
            low_next = low_gate_reg || (both_off && dead_done);
            stretch  = both_off && !dead_done;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         high_gate_reg     <= 1'b0;
         low_gate_reg      <= 1'b0;
         prev_req_high_reg <= 1'b0;
         prev_req_low_reg  <= 1'b0;
         stretch_prev_reg  <= 1'b0;
      end else begin
         high_gate_reg     <= high_next;
         low_gate_reg      <= low_next;
         prev_req_high_reg <= req_high;
         prev_req_low_reg  <= req_low;
         stretch_prev_reg  <= stretch;
      end
   end

   // Charge window after a command release leaves the bridge in tri-state.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         win_mode_reg <= hbg_pkg::HBG_WIN_IDLE;
         win_cnt_reg  <= 12'h000;
      end else if (prev_req_low_reg && !req_low && !req_high) begin
         win_mode_reg <= hbg_pkg::HBG_WIN_FIXED;
         win_cnt_reg  <= 12'h000;
      end else if (prev_req_high_reg && !req_high && !req_low) begin
         win_mode_reg <= hbg_pkg::HBG_WIN_RETRIG;
         win_cnt_reg  <= 12'h000;
      end else begin
         case (win_mode_reg)
            hbg_pkg::HBG_WIN_FIXED,
            hbg_pkg::HBG_WIN_RETRIG: begin
               if (!both_off) begin
                  win_mode_reg <= hbg_pkg::HBG_WIN_IDLE;
               end else if (win_mode_reg == hbg_pkg::HBG_WIN_RETRIG && sense_s.vb_high) begin
                  win_cnt_reg <= 12'h000;
               end else if (win_cnt_reg == 12'(WIN_CYC - 1)) begin
                  win_mode_reg <= hbg_pkg::HBG_WIN_IDLE;
               end else begin
                  win_cnt_reg <= win_cnt_reg + 12'h001;
               end
            end
            default: begin
               win_cnt_reg <= 12'h000;
            end
         endcase
      end
   end

   // Bootstrap switch: off conditions win, and high_next opens it on the edge the high gate closes.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         boot_reg <= 1'b0;
      end else if (high_gate_reg || high_next || sense_s.vb_high) begin
         boot_reg <= 1'b0;
      end else if (low_gate_reg) begin
         boot_reg <= 1'b1;
      end else if (win_mode_reg != hbg_pkg::HBG_WIN_IDLE && both_off) begin
         boot_reg <= 1'b1;
      end
   end

   assign high_gate_out   = high_gate_reg;
   assign low_gate_out    = low_gate_reg;
   assign boot_switch_out = boot_reg;
   assign fault_n_out     = logic_ok_reg;

   // Sticky events; a new event wins over a clear in the same cycle.
   assign events[`HBG_EV_LOGIC_UV] = sense_s.logic_below_lower && logic_ok_reg;
   assign events[`HBG_EV_FLOAT_UV] = sense_s.float_below_lower && float_ok_reg;
   assign events[`HBG_EV_STRETCH]  = stretch && !stretch_prev_reg;
   assign events[`HBG_EV_CROSS]    = req_high && req_low;

   assign wb_req   = wb_cyc_in && wb_stb_in && !ack_reg;
   assign wr_lane0 = wb_req && wb_we_in && wb_sel_in[0];

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         irq_stat_reg <= '0;
      end else if (wr_lane0 && hit(wb_adr_in, `HBG_ADR_IRQ_CLR)) begin
         irq_stat_reg <= (irq_stat_reg & ~wb_dat_in[`HBG_EV_WIDTH-1:0]) | events;
      end else begin
         irq_stat_reg <= irq_stat_reg | events;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         ctrl_drive_en_reg <= `HBG_CTRL_RESET;
         irq_en_reg        <= '0;
      end else if (wr_lane0) begin
         if (hit(wb_adr_in, `HBG_ADR_CTRL)) begin
            ctrl_drive_en_reg <= wb_dat_in[`HBG_CTRL_DRIVE_EN];
         end
         if (hit(wb_adr_in, `HBG_ADR_IRQ_EN)) begin
            irq_en_reg <= wb_dat_in[`HBG_EV_WIDTH-1:0];
         end
      end
   end

   assign irq_out = |(irq_stat_reg & irq_en_reg);

   // One-wait-state answer; unmapped addresses are acknowledged and read zero.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= wb_req;
         dat_reg <= 32'h0000_0000;
         if (wb_req && !wb_we_in) begin
            if (hit(wb_adr_in, `HBG_ADR_CTRL)) begin
               dat_reg[`HBG_CTRL_DRIVE_EN] <= ctrl_drive_en_reg;
            end
            if (hit(wb_adr_in, `HBG_ADR_STATUS)) begin
               dat_reg[`HBG_ST_HIGH_GATE] <= high_gate_reg;
               dat_reg[`HBG_ST_LOW_GATE]  <= low_gate_reg;
               dat_reg[`HBG_ST_BOOT]      <= boot_reg;
               dat_reg[`HBG_ST_LOGIC_OK]  <= logic_ok_reg;
               dat_reg[`HBG_ST_FLOAT_OK]  <= float_ok_reg;
               dat_reg[`HBG_ST_VB_HIGH]   <= sense_s.vb_high;
               dat_reg[`HBG_ST_WIN_OPEN]  <= (win_mode_reg != hbg_pkg::HBG_WIN_IDLE);
            end
            if (hit(wb_adr_in, `HBG_ADR_IRQ_STAT)) begin
               dat_reg[`HBG_EV_WIDTH-1:0] <= irq_stat_reg;
            end
            if (hit(wb_adr_in, `HBG_ADR_IRQ_EN)) begin
               dat_reg[`HBG_EV_WIDTH-1:0] <= irq_en_reg;
            end
         end
      end
   end

   assign wb_ack_out = ack_reg;
   assign wb_dat_out = dat_reg;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);

   property p_never_both;
      !(high_gate_reg && low_gate_reg);
   endproperty
   a_never_both: assert property (p_never_both)
      else $error("Both gates on together.");

   property p_dead_high;
      $rose(high_gate_reg) |-> $past(both_off) && $past(dead_cnt_reg) >= 7'(DEAD_CYC);
   endproperty
   a_dead_high: assert property (p_dead_high)
      else $error("High gate turned on inside the deadtime.");

   property p_dead_low;
      $rose(low_gate_reg) |-> $past(both_off) && $past(dead_cnt_reg) >= 7'(DEAD_CYC);
   endproperty
   a_dead_low: assert property (p_dead_low)
      else $error("Low gate turned on inside the deadtime.");

   property p_long_gap;
      (req_high && !req_low && both_off && dead_done && logic_ok_reg && float_ok_reg
       && ctrl_drive_en_reg) |=> high_gate_reg;
   endproperty
   a_long_gap: assert property (p_long_gap)
      else $error("Long gap was delayed further.");

   property p_off_latency;
      (!req_high |=> !high_gate_reg) and (!req_low |=> !low_gate_reg);
   endproperty
   a_off_latency: assert property (p_off_latency)
      else $error("Turn-off latency mismatch.");

   property p_cross;
      (req_high && req_low) |=> both_off;
   endproperty
   a_cross: assert property (p_cross)
      else $error("Simultaneous requests drove a gate.");

   property p_logic_uv;
      sense_s.logic_below_lower |=> !fault_n_out ##1 both_off;
   endproperty
   a_logic_uv: assert property (p_logic_uv)
      else $error("Logic lockout did not act.");

   property p_float_uv;
      sense_s.float_below_lower |=> ##1 !high_gate_reg;
   endproperty
   a_float_uv: assert property (p_float_uv)
      else $error("Floating lockout did not block high gate.");

   property p_boot_off;
      (high_gate_reg |-> !boot_reg) and (sense_s.vb_high |=> !boot_reg);
   endproperty
   a_boot_off: assert property (p_boot_off)
      else $error("Bootstrap switch on while forbidden.");

   property p_boot_on;
      (low_gate_reg && !high_gate_reg && !sense_s.vb_high) |=> boot_reg;
   endproperty
   a_boot_on: assert property (p_boot_on)
      else $error("Bootstrap switch not on with low gate.");

   property p_retrig_hold;
      (win_mode_reg == hbg_pkg::HBG_WIN_RETRIG && both_off && sense_s.vb_high
       && !(prev_req_low_reg || prev_req_high_reg)) |=> win_cnt_reg == 12'h000;
   endproperty
   a_retrig_hold: assert property (p_retrig_hold)
      else $error("Retrigger window counted while supply high.");

   property p_win_end;
      (win_mode_reg == hbg_pkg::HBG_WIN_FIXED && win_cnt_reg == 12'(WIN_CYC - 1)
       && both_off && !prev_req_low_reg && !prev_req_high_reg)
       |=> win_mode_reg == hbg_pkg::HBG_WIN_IDLE;
   endproperty
   a_win_end: assert property (p_win_end)
      else $error("Fixed window outlived its length.");

endmodule
`default_nettype wire

// [test/hbg_ctrl_model.sv]
// Controller model that drives the gate commands of the half-bridge logic.
`timescale 1ns/1ps
`default_nettype none
module hbg_ctrl_model (
   // Requested phase: 1 high, 2 low, 3 both.
   input  wire logic [1:0] phase_in,
   // Commands toward the gate logic.
   output logic            high_side_cmd_out,
   output logic            low_side_cmd_n_out
);
   // Phases alternate; phase 3 exists only to provoke the overlap guard.
   always_comb begin
      high_side_cmd_out  = phase_in[0];
      low_side_cmd_n_out = ~phase_in[1];
   end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the half-bridge gate logic.
`timescale 1ns/1ps
`default_nettype none
`include "hbg_defines.svh"
module testbench;
   logic                clock_in;
   logic                nrst_in;
   logic [1:0]          phase;
   logic                hi_cmd;
   logic                lo_cmd_n;
   hbg_pkg::hbg_sense_s sense;
   logic                hi_g;
   logic                lo_g;
   logic                boot;
   logic                fault_n;
   logic                irq;
   logic                wb_cyc;
   logic                wb_stb;
   logic                wb_we;
   logic [7:0]          wb_adr;
   logic [31:0]         wb_wdat;
   logic [31:0]         wb_rdat;
   logic                wb_ack;
   logic [31:0]         q;
   int                  error_cnt;
   int                  checks;
   int                  cyc_cnt;
   int                  n;
   int                  gap;
   wire  [3:0]          outs = {fault_n, boot, lo_g, hi_g};

   hbg_ctrl_model hbg_ctrl_model_inst (
      .phase_in          (phase),
      .high_side_cmd_out (hi_cmd),
      .low_side_cmd_n_out(lo_cmd_n)
   );

   hbg_gate_logic hbg_gate_logic_inst (
      .clock_in         (clock_in),
      .nrst_in          (nrst_in),
      .high_side_cmd_in (hi_cmd),
      .low_side_cmd_n_in(lo_cmd_n),
      .sense_in         (sense),
      .high_gate_out    (hi_g),
      .low_gate_out     (lo_g),
      .boot_switch_out  (boot),
      .fault_n_out      (fault_n),
      .irq_out          (irq),
      .wb_cyc_in        (wb_cyc),
      .wb_stb_in        (wb_stb),
      .wb_we_in         (wb_we),
      .wb_adr_in        (wb_adr),
      .wb_sel_in        (4'hF),
      .wb_dat_in        (wb_wdat),
      .wb_dat_out       (wb_rdat),
      .wb_ack_out       (wb_ack)
   );

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clock_in);
      #1;
   endtask

   task automatic drive(input logic [1:0] p);
      @(posedge clock_in);
      phase <= p;
   endtask

   // Counts edges until output bit i settles at v.
   task automatic wait_out(input int i, input logic v, output int c);
      c = 0;
      #1;
      while (outs[i] !== v && c < 5000) begin
         @(posedge clock_in);
         #1;
         c++;
      end
      if (outs[i] !== v) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: output wait timed out", $time);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= a;
      wb_wdat <= d;
      do begin
         @(posedge clock_in);
      end while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask

   task automatic t_power_up();
      chk(outs === 4'h0, "outputs after reset");
      wb(1'b0, `HBG_ADR_CTRL, 32'h0);
      chk(q === 32'h0000_0001, "ctrl reset value");
      wb(1'b0, 8'h20, 32'h0);
      chk(q === 32'h0000_0000, "unmapped read");
      drive(2'd1);
      tick(150);
      chk(hi_g === 1'b0, "high gate before logic ok");
      @(posedge clock_in);
      sense.logic_above_upper <= 1'b1;
      tick(20);
      chk(hi_g === 1'b0 && fault_n === 1'b1, "high before float ok");
      @(posedge clock_in);
      sense.float_above_upper <= 1'b1;
      wait_out(0, 1'b1, n);
      chk(n <= 5, "high gate after supplies good");
      wb(1'b0, `HBG_ADR_STATUS, 32'h0);
      chk(q === 32'h0000_0019, "status with high gate on");
      $display("power up done");
   endtask

   task automatic t_handover();
      drive(2'd2);
      wait_out(0, 1'b0, n);
      chk(n === 3, "high turn-off latency");
      wait_out(1, 1'b1, gap);
      chk(gap >= `HBG_DEAD_CYC && lo_g === 1'b1, "deadtime high to low");
      wait_out(2, 1'b1, n);
      chk(n === 1, "boot on with low gate");
      drive(2'd1);
      wait_out(1, 1'b0, n);
      chk(n === 3, "low turn-off latency");
      wait_out(0, 1'b1, n);
      chk(n === gap, "deadtime symmetric");
      chk(lo_g === 1'b0 && boot === 1'b0, "boot off with high");
      drive(2'd0);
      tick(200);
      drive(2'd2);
      wait_out(1, 1'b1, n);
      chk(n === 3, "long gap not stretched");
      $display("handover done");
   endtask

   task automatic t_boot();
      @(posedge clock_in);
      sense.vb_high <= 1'b1;
      wait_out(2, 1'b0, n);
      chk(n <= 4, "boot off on high supply");
      drive(2'd0);
      tick(50);
      @(posedge clock_in);
      sense.vb_high <= 1'b0;
      wait_out(2, 1'b1, n);
      chk(n <= 4, "boot in low-release window");
      @(posedge clock_in);
      sense.vb_high <= 1'b1;
      drive(2'd2);
      tick(10);
      drive(2'd0);
      tick(4100);
      @(posedge clock_in);
      sense.vb_high <= 1'b0;
      tick(10);
      chk(boot === 1'b0, "fixed window expired");
      @(posedge clock_in);
      sense.vb_high <= 1'b1;
      drive(2'd1);
      tick(10);
      drive(2'd0);
      tick(4100);
      @(posedge clock_in);
      sense.vb_high <= 1'b0;
      wait_out(2, 1'b1, n);
      chk(n <= 4, "retriggerable window held");
      $display("bootstrap done");
   endtask

   task automatic t_overlap_irq();
      wb(1'b1, `HBG_ADR_IRQ_EN, 32'h0);
      drive(2'd3);
      tick(20);
      chk(hi_g === 1'b0 && lo_g === 1'b0, "both gates off");
      chk(irq === 1'b0, "masked interrupt");
      wb(1'b0, `HBG_ADR_IRQ_STAT, 32'h0);
      chk(q[3] === 1'b1, "overlap event");
      wb(1'b1, `HBG_ADR_IRQ_EN, 32'h0000_0008);
      tick(2);
      chk(irq === 1'b1, "interrupt raised");
      drive(2'd0);
      tick(5);
      wb(1'b1, `HBG_ADR_IRQ_CLR, 32'h0000_0008);
      tick(2);
      chk(irq === 1'b0, "interrupt cleared");
      wb(1'b1, `HBG_ADR_CTRL, 32'h0);
      drive(2'd1);
      tick(150);
      chk(hi_g === 1'b0, "high gate while drive disabled");
      wb(1'b1, `HBG_ADR_CTRL, 32'h0000_0001);
      wait_out(0, 1'b1, n);
      chk(n <= 4, "high gate after drive enabled");
      drive(2'd0);
      $display("overlap done");
   endtask

   task automatic t_lockout();
      drive(2'd2);
      tick(200);
      @(posedge clock_in);
      sense.float_above_upper <= 1'b0;
      sense.float_below_lower <= 1'b1;
      tick(10);
      chk(lo_g === 1'b1, "low survives float lockout");
      drive(2'd1);
      tick(200);
      chk(hi_g === 1'b0, "high blocked by float lockout");
      @(posedge clock_in);
      sense.float_below_lower <= 1'b0;
      sense.float_above_upper <= 1'b1;
      wait_out(0, 1'b1, n);
      @(posedge clock_in);
      sense.logic_above_upper <= 1'b0;
      sense.logic_below_lower <= 1'b1;
      wait_out(0, 1'b0, n);
      chk(n <= 5 && fault_n === 1'b0, "logic lockout");
      $display("lockout done");
   endtask

   initial begin
      nrst_in = 1'b0;
      phase = 2'd0;
      sense = '0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_wdat = 32'h0000_0000;
      error_cnt = 0;
      checks = 0;
      cyc_cnt = 0;
      repeat (20) @(posedge clock_in);
      nrst_in <= 1'b1;
      tick(1);
      // Ceiling leaves ample margin over the planned sequence.
      fork
         begin
            t_power_up();
            t_handover();
            t_boot();
            t_overlap_irq();
            t_lockout();
         end
         begin
            while (cyc_cnt < 30000) begin
               @(posedge clock_in);
               cyc_cnt++;
            end
            error_cnt++;
            $display("CHECK FAILED at %0t: run timed out", $time);
         end
      join_any
      complete_run();
   end
endmodule
`default_nettype wire
